// ==== lcc_cell.sv ====
// one logic cell: input mux, gates and function; output registered on the clock in every mode
module lcc_cell
	import lcc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [LCC_NUM_INPUTS-1:0] src_i,
	input wire lcc_route_s route_i,
	input wire logic [LCC_FUNC_W-1:0] func_i,
	input wire logic enable_i,
	input wire logic out_pol_i,
	output logic out_o
);
	logic [LCC_NUM_GATES-1:0] sel_data;
	logic [LCC_NUM_GATES-1:0] gate;
	logic st;
	logic comb_f;
	logic next_st;

	genvar g;
	generate
		for (g = 0; g < LCC_NUM_GATES; g++)
		begin : g_gate
			assign sel_data[g] = src_i[route_i.input_select[g]];
			// gate g: or of true/complement of all four selected data
			assign gate[g] = route_i.gate_polarity[g] ^
				(|(route_i.gate_select[g] & {~sel_data[3], sel_data[3], ~sel_data[2], sel_data[2],
				~sel_data[1], sel_data[1], ~sel_data[0], sel_data[0]}));
		end
	endgenerate

	// combinational function select
	assign comb_f = (func_i == LCC_FN_AND_OR) ? ((gate[0] & gate[1]) | (gate[2] & gate[3])) :
		(func_i == LCC_FN_OR_XOR) ? ((gate[0] | gate[1]) ^ (gate[2] | gate[3])) :
		(func_i == LCC_FN_AND4) ? (&gate) :
		(func_i == LCC_FN_LATCH_SR) ? (~gate[2] & (gate[0] | gate[1] | st)) : st;

	// stored modes, next state loaded on every system clock edge; no gate acts as clock
	assign next_st = (func_i == LCC_FN_SR) ? ((gate[0] | gate[1]) | (st & ~(gate[2] | gate[3]))) :
		(func_i == LCC_FN_DFF_SR) ? (gate[3] ? 1'b0 : (gate[2] ? 1'b1 : gate[1])) :
		(func_i == LCC_FN_DFF_R) ? (gate[2] ? 1'b0 : (gate[1] & gate[3])) :
		(func_i == LCC_FN_JK_R) ? (gate[2] ? 1'b0 : ((gate[1] & ~st) | (~gate[3] & st))) :
		(func_i == LCC_FN_LATCH_SR) ? comb_f : st;

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			st <= 1'b0;
		else if (!enable_i)
			st <= 1'b0;
		else
			st <= next_st;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
			out_o <= 1'b0;
		else
			out_o <= enable_i & (comb_f ^ out_pol_i);
	end
endmodule

// ==== lcc_pkg.sv ====
// package of constants and carriers for the configurable logic cell block
package lcc_pkg;
	localparam int unsigned LCC_NUM_CELLS = 4;
	localparam int unsigned LCC_NUM_INPUTS = 8;
	localparam int unsigned LCC_SEL_W = 3;
	localparam int unsigned LCC_NUM_GATES = 4;
	localparam int unsigned LCC_FUNC_W = 3;
	localparam logic [7:0] LCC_CTRL_RESET = 8'h00;
	// logic function codes
	localparam logic [2:0] LCC_FN_AND_OR = 3'h0;
	localparam logic [2:0] LCC_FN_OR_XOR = 3'h1;
	localparam logic [2:0] LCC_FN_AND4 = 3'h2;
	localparam logic [2:0] LCC_FN_SR = 3'h3;
	localparam logic [2:0] LCC_FN_DFF_SR = 3'h4;
	localparam logic [2:0] LCC_FN_DFF_R = 3'h5;
	localparam logic [2:0] LCC_FN_JK_R = 3'h6;
	localparam logic [2:0] LCC_FN_LATCH_SR = 3'h7;

	// cell control register image
	typedef struct packed {
		logic cell_enable;
		logic cell_output_bit;
		logic rise_irq_enable;
		logic fall_irq_enable;
		logic [LCC_FUNC_W-1:0] logic_function_select;
		logic output_polarity;
	} lcc_ctrl_s;

	// selection and gating settings of one cell
	typedef struct packed {
		logic [LCC_NUM_GATES-1:0][LCC_SEL_W-1:0] input_select;
		logic [LCC_NUM_GATES-1:0][LCC_NUM_GATES*2-1:0] gate_select;
		logic [LCC_NUM_GATES-1:0] gate_polarity;
	} lcc_route_s;
endpackage

// ==== lcc_src_model.sv ====
// model of the sources feeding the cells, with the fast internal oscillator on top
module lcc_src_model
	import lcc_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [LCC_NUM_INPUTS-2:0] req_i,
	input wire logic osc_run_i,
	output logic [LCC_NUM_INPUTS-1:0] src_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic osc = 1'b0;
	// oscillator toggles only while kept alive
	always @(posedge ref_clk_i) osc <= osc_run_i ? ~osc : osc;
	assign src_o = {osc, req_i};
endmodule

// ==== lcc_top.sv ====
// logic cell array with edge interrupts, output mirror and sleep keep-alive
//
// Contract
// - every cell has its own rising and falling edge detector on output
// - flag sets on an enabled rise or fall edge of the cell output
// - hardware never clears the flag; software clears it
// - an edge in the clearing cycle still leaves the flag set
// - mirror register holds all cell outputs sampled in one instant
// - any reset clears every cell control register to zero
// - reset leaves input select, gate select and gate polarity untouched
// - cells keep running in sleep while their inputs stay active
// - enabled cell using fast oscillator keeps that oscillator running in sleep
// - oscillator as system clock and cell input: processor idles, cell runs
// - cell applies the chosen 3-bit function and the output inversion
module lcc_top
	import lcc_pkg::*;
#(
	parameter int unsigned NUM_CELLS = LCC_NUM_CELLS,
	parameter int unsigned FAST_OSC_SRC = 7
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [LCC_NUM_INPUTS-1:0] src_i,
	input wire lcc_route_s [NUM_CELLS-1:0] route_i,
	input wire logic [NUM_CELLS-1:0] ctrl_wr_i,
	input wire lcc_ctrl_s [NUM_CELLS-1:0] ctrl_wdata_i,
	input wire logic [NUM_CELLS-1:0] flag_clr_i,
	input wire logic sleep_i,
	input wire logic fast_osc_is_sysclk_i,
	output lcc_ctrl_s [NUM_CELLS-1:0] ctrl_o,
	output lcc_route_s [NUM_CELLS-1:0] route_o,
	output logic [NUM_CELLS-1:0] cell_irq_flag_o,
	output logic [NUM_CELLS-1:0] output_mirror_reg_o,
	output logic fast_osc_keep_o,
	output logic cpu_idle_o
);
	if (NUM_CELLS < 1 || NUM_CELLS > 8 || FAST_OSC_SRC >= LCC_NUM_INPUTS)
	begin : g_bad_param
		$error("lcc_top: unsupported parameters");
	end

	//--------------------------------------------------------------
	// control registers and cells
	//--------------------------------------------------------------
	lcc_ctrl_s [NUM_CELLS-1:0] ctrl;
	lcc_route_s [NUM_CELLS-1:0] route;
	logic [NUM_CELLS-1:0] cell_out;
	logic [NUM_CELLS-1:0] prev_out;
	logic [NUM_CELLS-1:0] flag;
	logic [NUM_CELLS-1:0] uses_fast_osc;

	function automatic logic route_uses(input lcc_route_s r, input int unsigned src);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < LCC_NUM_GATES; k++)
			hit = hit | (r.input_select[k] == LCC_SEL_W'(src));
		return hit;
	endfunction

	genvar c;
	generate
		for (c = 0; c < NUM_CELLS; c++)
		begin : g_cell
			logic rise_ev;
			logic fall_ev;
			logic next_flag;
			logic set_ev;
			logic [7:0] ctrl_bits;

			// edge detectors on the cell output
			assign rise_ev = cell_out[c] & ~prev_out[c];
			assign fall_ev = ~cell_out[c] & prev_out[c];
			// set wins over clear, no hardware clear
			assign set_ev = (rise_ev & ctrl[c].rise_irq_enable) | (fall_ev & ctrl[c].fall_irq_enable);
			assign next_flag = set_ev | (flag[c] & ~flag_clr_i[c]);
			assign uses_fast_osc[c] = ctrl[c].cell_enable & route_uses(route[c], FAST_OSC_SRC);
			assign ctrl_bits = ctrl_wdata_i[c];

			lcc_cell u_cell (
				.ref_clk_i(ref_clk_i),
				.rst_i(rst_i),
				.src_i(src_i),
				.route_i(route[c]),
				.func_i(ctrl[c].logic_function_select),
				.enable_i(ctrl[c].cell_enable),
				.out_pol_i(ctrl[c].output_polarity),
				.out_o(cell_out[c])
			);

			always_ff @(posedge ref_clk_i or posedge rst_i)
			begin
				if (rst_i)
					ctrl[c] <= LCC_CTRL_RESET;
				else if (ctrl_wr_i[c])
					ctrl[c] <= {ctrl_bits[7], cell_out[c], ctrl_bits[5:0]};
				else
					ctrl[c].cell_output_bit <= cell_out[c];
			end

			// selection state has no reset branch
			always_ff @(posedge ref_clk_i)
			begin
				route[c] <= route_i[c];
			end

			always_ff @(posedge ref_clk_i or posedge rst_i)
			begin
				if (rst_i)
				begin
					prev_out[c] <= 1'b0;
					flag[c] <= 1'b0;
				end
				else
				begin
					prev_out[c] <= cell_out[c];
					flag[c] <= next_flag;
				end
			end

			AST_FLAG_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(rise_ev & ctrl[c].rise_irq_enable) |=> flag[c])
				else $error("flag not set on enabled rise");
			AST_FLAG_FALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(fall_ev & ctrl[c].fall_irq_enable) |=> flag[c])
				else $error("flag not set on enabled fall");
			AST_FLAG_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(flag[c] & ~flag_clr_i[c]) |=> flag[c])
				else $error("flag dropped without clear");
			AST_SET_WINS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(flag_clr_i[c] & rise_ev & ctrl[c].rise_irq_enable) |=> flag[c])
				else $error("edge lost during clear");
			AST_FALL_WINS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(flag_clr_i[c] & fall_ev & ctrl[c].fall_irq_enable) |=> flag[c])
				else $error("fall edge lost during clear");
			AST_NO_SPURIOUS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(!flag[c] & !rise_ev & !fall_ev) |=> !flag[c])
				else $error("flag set without edge");
			AST_FLAG_NEEDS_EN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(!flag[c] & !(rise_ev & ctrl[c].rise_irq_enable) & !(fall_ev & ctrl[c].fall_irq_enable)) |=> !flag[c])
				else $error("flag set by a disabled edge");
			AST_CLEAR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				(flag_clr_i[c] & !rise_ev & !fall_ev) |=> !flag[c])
				else $error("clear ignored");
			AST_FLAG_OUT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				##1 cell_irq_flag_o[c] == $past(flag[c]))
				else $error("flag output not a copy of the flag");
			AST_OUT_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				!ctrl[c].cell_enable |=> !cell_out[c])
				else $error("disabled cell drives high");
			AST_CTRL_WR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				ctrl_wr_i[c] |=> {ctrl[c].cell_enable, ctrl[c][5:0]} ==
				{$past(ctrl_wdata_i[c].cell_enable), $past(ctrl_wdata_i[c][5:0])})
				else $error("control write not taken");
			AST_CTRL_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				!ctrl_wr_i[c] |=> {ctrl[c].cell_enable, ctrl[c][5:0]} ==
				$past({ctrl[c].cell_enable, ctrl[c][5:0]}))
				else $error("control changed without write");
			AST_ROUTE_HOLD: assert property (@(posedge ref_clk_i)
				##1 route[c] == $past(route_i[c]))
				else $error("selection changed by reset");
			AST_OUTBIT_MIRROR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
				output_mirror_reg_o[c] == ctrl[c].cell_output_bit)
				else $error("mirror and output bit disagree");

			COV_RISE: cover property (@(posedge ref_clk_i) disable iff (rst_i) rise_ev & ctrl[c].rise_irq_enable);
			COV_FALL: cover property (@(posedge ref_clk_i) disable iff (rst_i) fall_ev & ctrl[c].fall_irq_enable);
			COV_CLR_EDGE: cover property (@(posedge ref_clk_i) disable iff (rst_i) flag_clr_i[c] & rise_ev);
		end
	endgenerate

	//--------------------------------------------------------------
	// mirror, sleep and outputs
	//--------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			output_mirror_reg_o <= '0;
			cell_irq_flag_o <= '0;
			fast_osc_keep_o <= 1'b0;
			cpu_idle_o <= 1'b0;
		end
		else
		begin
			output_mirror_reg_o <= cell_out;
			cell_irq_flag_o <= flag;
			fast_osc_keep_o <= sleep_i & (|uses_fast_osc);
			cpu_idle_o <= sleep_i;
		end
	end

	assign ctrl_o = ctrl;
	assign route_o = route;

	//--------------------------------------------------------------
	// checks of the shared outputs
	//--------------------------------------------------------------
	AST_MIRROR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		##1 output_mirror_reg_o == $past(cell_out))
		else $error("mirror not a one-instant copy");
	AST_OSC_KEEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sleep_i & |uses_fast_osc) |=> fast_osc_keep_o)
		else $error("fast oscillator not kept in sleep");
	AST_KEEP_NEED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!(sleep_i & |uses_fast_osc) |=> !fast_osc_keep_o)
		else $error("fast oscillator kept without need");
	AST_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		(sleep_i & fast_osc_is_sysclk_i & |uses_fast_osc) |=> (cpu_idle_o & fast_osc_keep_o))
		else $error("processor not idle with oscillator kept");
	AST_IDLE_FOLLOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		##1 cpu_idle_o == $past(sleep_i))
		else $error("idle does not follow sleep");
	AST_RESET_CTRL: assert property (@(posedge ref_clk_i)
		rst_i |-> ctrl == '0)
		else $error("control not cleared by reset");
	COV_SLEEP_OSC: cover property (@(posedge ref_clk_i) disable iff (rst_i) sleep_i & |uses_fast_osc);
	COV_IDLE_SYS: cover property (@(posedge ref_clk_i) disable iff (rst_i)
		sleep_i & fast_osc_is_sysclk_i & |uses_fast_osc);
endmodule

// ==== tb_lcc_top.sv ====
// self-checking testbench of the logic cell array
module tb_lcc_top
	import lcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b0;
	logic [6:0] req = '0;
	logic [7:0] src;
	lcc_route_s [3:0] route = '0;
	lcc_route_s [3:0] route_q;
	lcc_ctrl_s [3:0] wd = '0;
	lcc_ctrl_s [3:0] ctrl;
	logic [3:0] wr = '0;
	logic [3:0] clr = '0;
	logic [3:0] flag, mirror, re, fe, pol;
	logic sleep = 1'b0;
	logic fsys = 1'b0;
	logic keep, idle;
	logic [2:0] fn;
	logic [3:0] st_m = '0;
	logic [3:0] ex;
	int fail_count = 0;
	int cmp_count = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	lcc_src_model lcc_src_model_i (.ref_clk_i(ref_clk_i), .req_i(req), .osc_run_i(~idle | keep), .src_o(src));
	lcc_top lcc_top_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .src_i(src), .route_i(route), .ctrl_wr_i(wr),
		.ctrl_wdata_i(wd), .flag_clr_i(clr), .sleep_i(sleep), .fast_osc_is_sysclk_i(fsys), .ctrl_o(ctrl),
		.route_o(route_q), .cell_irq_flag_o(flag), .output_mirror_reg_o(mirror), .fast_osc_keep_o(keep),
		.cpu_idle_o(idle));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic test_done();
		if (fail_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wctl(input logic [3:0] en, input logic [3:0] r, input logic [3:0] f, input logic [2:0] func,
		input logic [3:0] p);
		for (int i = 0; i < 4; i++)
			wd[i] = '{en[i], 1'b0, r[i], f[i], func, p[i]};
		wr = 4'hF;
		step(1);
		wr = '0;
	endtask
	// settled stored state of the cells once every gate carries x
	function automatic logic [3:0] st_next(input logic [2:0] func, input logic [3:0] x, input logic [3:0] s);
		case (func)
			LCC_FN_SR: return x;
			LCC_FN_DFF_SR, LCC_FN_DFF_R: return 4'h0;
			LCC_FN_JK_R, LCC_FN_LATCH_SR: return s & ~x;
			default: return s;
		endcase
	endfunction
	// expected cell output with all gates passing the same source
	function automatic logic [3:0] exp_out(input logic [2:0] func, input logic [3:0] x, input logic [3:0] s,
		input logic [3:0] p);
		if (func == LCC_FN_AND_OR || func == LCC_FN_AND4)
			return x ^ p;
		else if (func == LCC_FN_OR_XOR)
			return p;
		else
			return st_next(func, x, s) ^ p;
	endfunction
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		#100us;
		fail_count++;
		test_done();
	end
	initial
	begin
		void'($urandom(74));
		#1;
		rst_i = 1'b1;
		step(2);
		rst_i = 1'b0;
		wctl(4'h0, 4'h0, 4'h0, LCC_FN_AND4, 4'h0);
		for (int i = 0; i < 4; i++)
		begin
			route[i].input_select = {4{3'(i)}};
			route[i].gate_select = {4{8'h01}};
			route[i].gate_polarity = 4'h0;
		end
		for (int k = 0; k < 24; k++)
		begin
			fn = 3'(k % 8);
			pol = 4'($urandom);
			sleep = 1'($urandom);
			fsys = 1'($urandom);
			wctl(4'hF, 4'h0, 4'h0, fn, pol);
			req[3:0] = 4'($urandom);
			step(3);
			ex = exp_out(fn, req[3:0], st_m, pol);
			st_m = st_next(fn, req[3:0], st_m);
			chk(mirror, ex);
			chk(ctrl[1].cell_output_bit, ex[1]);
			chk({ctrl[2].logic_function_select, ctrl[2].output_polarity}, {fn, pol[2]});
			chk(idle, sleep);
			chk(keep, 1'b0);
		end
		sleep = 1'b0;
		for (int k = 0; k < 4; k++)
		begin
			re = (k == 0) ? 4'hF : 4'($urandom);
			fe = (k == 0) ? 4'h0 : 4'($urandom);
			req[3:0] = 4'h0;
			wctl(4'hF, re, fe, LCC_FN_AND4, 4'h0);
			step(3);
			clr = 4'hF;
			step(1);
			clr = '0;
			req[3:0] = 4'hF;
			step(4);
			chk(flag, re);
			step(10);
			chk(flag, re);
			clr = 4'hF;
			step(1);
			clr = '0;
			req[3:0] = 4'h0;
			step(4);
			chk(flag, fe);
			clr = 4'hF;
			req[3:0] = 4'hF;
			step(2);
			clr = '0;
			step(3);
			chk(flag, re);
		end
		route[3].input_select = {4{3'h7}};
		wctl(4'h8, 4'h0, 4'h0, LCC_FN_AND4, 4'h0);
		sleep = 1'b1;
		fsys = 1'b1;
		step(3);
		chk(keep, 1'b1);
		chk(idle, 1'b1);
		req[3:0] = 4'h0;
		step(3);
		chk(mirror[3], src[7]);
		sleep = 1'b0;
		step(3);
		chk(keep, 1'b0);
		rst_i = 1'b1;
		step(2);
		chk(ctrl, '0);
		chk(route_q, route);
		rst_i = 1'b0;
		step(2);
		chk(ctrl, '0);
		chk(mirror, 4'h0);
		test_done();
	end
endmodule
